// ==== port_power_pkg.sv ====
// Shared constants and types for the port power pad and source select block.
// Assumes a word-wide register bus where each register index sits at
// four times its index in byte addresses.
package port_power_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [13:0] IDX_PULLDOWN = 14'h092e;
   localparam logic [13:0] IDX_DIRECTION = 14'h0932;
   localparam logic [13:0] IDX_OUTPUT = 14'h0936;
   localparam logic [13:0] IDX_INPUT = 14'h093a;
   localparam logic [13:0] IDX_PULLUP = 14'h093e;
   localparam logic [13:0] IDX_SELECT1 = 14'h3c00;
   localparam logic [13:0] IDX_SELECT2 = 14'h3c04;
   localparam logic [13:0] IDX_STATUS = 14'h3c08;

   // Values after reset.
   localparam logic [7:1] PAD_RESET = 7'h00;
   localparam logic [7:0] SELECT_RESET = 8'h00;

   // Writable bits of the select registers; bit 6 reads as zero.
   localparam logic [7:0] SELECT_WRITE_MASK = 8'hbf;

   // Field positions inside a select register.
   localparam int unsigned SEL_COMBINED_BIT = 7;
   localparam int unsigned SEL_DISABLED_BIT = 5;
   localparam int unsigned SEL_NR_BIT = 4;

   // Field positions inside the status register.
   localparam int unsigned STAT_POWER_LSB = 0;
   localparam int unsigned STAT_OC_LSB = 2;
   localparam int unsigned STAT_DIS_LSB = 4;

   // Power source encodings.
   localparam logic [3:0] SRC_OFF = 4'h0;
   localparam logic [3:0] SRC_USB2 = 4'h1;
   localparam logic [3:0] SRC_USB3 = 4'h2;
   localparam logic [3:0] SRC_EITHER = 4'h3;
   localparam logic [3:0] SRC_GPIO = 4'h4;

   // One port's power select register.
   typedef struct packed {
      logic combined;
      logic reserved;
      logic disabled;
      logic non_removable_attached;
      logic [3:0] power_source_field;
   } power_select_t;

   // The three requests that may turn a port's power on.
   typedef struct packed {
      logic usb2;
      logic usb3;
      logic gpio;
   } power_request_t;

   // Register bus slave states.
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_t;

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for a group of level inputs.
// Assumes the inputs are slow levels; pulses shorter than a clock are lost.
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;

   // Only the second stage is read outside this module.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_o <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end

endmodule

// ==== power_source_select.sv ====
// Combinational choice of one port's power state from its select register.
// Assumes the select register is stable during operation.
`timescale 1ns/1ps
module power_source_select
   import port_power_pkg::*;
(
   input wire power_select_t select_i,
   input wire power_request_t request_i,
   output logic power_on_o
);

   // Decodes the source field; reserved codes keep the port unpowered.
   function automatic logic source_on(input logic [3:0] src,
                                      input power_request_t req);
      unique case (src)
         SRC_OFF: source_on = 1'b0;
         SRC_USB2: source_on = req.usb2;
         SRC_USB3: source_on = req.usb3;
         SRC_EITHER: source_on = req.usb2 | req.usb3;
         SRC_GPIO: source_on = req.gpio;
         default: source_on = 1'b0;
      endcase
   endfunction

   // A permanently disabled port never receives power.
   always_comb begin
      power_on_o = source_on(select_i.power_source_field, request_i) &
                   ~select_i.disabled;
   end

endmodule

// ==== port_power_ctrl.sv ====
// Port power pad control and per-port power source selection.
// Assumes a classic Wishbone master on clk_i and external pad buffers
// that resolve the pad level from pad_out_o and pad_oe_n_o.
`timescale 1ns/1ps
module port_power_ctrl
   import port_power_pkg::*;
#(
   parameter int unsigned NUM_PORTS = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:1] pad_in_i,
   output logic [7:1] pad_out_o,
   output logic [7:1] pad_oe_n_o,
   output logic [7:1] pad_pullup_o,
   output logic [7:1] pad_pulldown_o,
   input wire logic [NUM_PORTS-1:0] usb2_power_on_i,
   input wire logic [NUM_PORTS-1:0] usb3_power_on_i,
   input wire logic [NUM_PORTS-1:0] gpio_power_i,
   input wire logic [NUM_PORTS-1:0] ocs_n_i,
   output logic [NUM_PORTS-1:0] port_power_on_o,
   output logic [NUM_PORTS-1:0] overcurrent_o,
   output logic [NUM_PORTS-1:0] port_disabled_o,
   output logic [NUM_PORTS-1:0] non_removable_attached_o,
   output logic [NUM_PORTS-1:0] shared_pin_mode_o
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   bus_state_t state_reg;
   bus_state_t state_next;
   logic [7:1] pulldown_reg;
   logic [7:1] direction_reg;
   logic [7:1] output_reg;
   logic [7:1] pullup_reg;
   power_select_t select_reg [NUM_PORTS];
   logic [7:1] pad_sync;
   logic [NUM_PORTS-1:0] gpio_sync;
   logic [NUM_PORTS-1:0] ocs_sync;
   logic [NUM_PORTS-1:0] power_on_next;
   logic [7:0] status_word;
   logic bus_req;
   logic commit_write;

   ////////////////////////////////////////////////////////////////////////
   // Address decode helpers.

   // True when the held bus address selects the given register index.
   function automatic logic addressed(input logic [15:0] adr,
                                      input logic [13:0] idx);
      addressed = (adr[15:2] == idx);
   endfunction

   // Read value of the register at the given address; unmapped reads zero.
   function automatic logic [7:0] read_byte(input logic [15:0] adr,
                                            input logic [7:0] sel1,
                                            input logic [7:0] sel2,
                                            input logic [7:0] stat);
      read_byte = 8'h00;
      if (addressed(adr, IDX_PULLDOWN)) begin
         read_byte = {pulldown_reg, 1'b0};
      end else if (addressed(adr, IDX_DIRECTION)) begin
         read_byte = {direction_reg, 1'b0};
      end else if (addressed(adr, IDX_OUTPUT)) begin
         read_byte = {output_reg, 1'b0};
      end else if (addressed(adr, IDX_INPUT)) begin
         read_byte = {pad_sync, 1'b0};
      end else if (addressed(adr, IDX_PULLUP)) begin
         read_byte = {pullup_reg, 1'b0};
      end else if (addressed(adr, IDX_SELECT1)) begin
         read_byte = sel1;
      end else if (addressed(adr, IDX_SELECT2)) begin
         read_byte = sel2;
      end else if (addressed(adr, IDX_STATUS)) begin
         read_byte = stat;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   // Pad levels come from outside the clock domain.
   pin_sync #(
      .WIDTH(7)
   ) u_pad_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pad_in_i),
      .sync_o(pad_sync)
   );

   // Sense is inverted first so the flops' reset value means no fault.
   pin_sync #(
      .WIDTH(2 * NUM_PORTS)
   ) u_port_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({gpio_power_i, ~ocs_n_i}),
      .sync_o({gpio_sync, ocs_sync})
   );

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave.

   assign bus_req = wb_cyc_i & wb_stb_i;
   // A write lands on the edge at which the master samples ack high.
   assign commit_write = (state_reg == BUS_ACK) & bus_req & wb_we_i &
                         wb_sel_i[0];

   // Every access is answered one cycle after it is seen, then ack drops.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         BUS_IDLE: begin
            if (bus_req) begin
               state_next = BUS_ACK;
            end
         end
         BUS_ACK: state_next = BUS_IDLE;
         default: state_next = BUS_IDLE;
      endcase
   end

   // Bus state and acknowledge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= BUS_IDLE;
         wb_ack_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         wb_ack_o <= (state_next == BUS_ACK);
      end
   end

   // Read data is captured with the ack so it stands for the whole answer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (state_reg == BUS_IDLE && bus_req && !wb_we_i) begin
         wb_dat_o <= {24'h00_0000,
                      read_byte(wb_adr_i, select_reg[0], select_reg[1],
                                status_word)};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pad control registers; bit 0 is reserved and reads as zero.

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulldown_reg <= PAD_RESET;
         direction_reg <= PAD_RESET;
         output_reg <= PAD_RESET;
         pullup_reg <= PAD_RESET;
      end else if (commit_write) begin
         if (addressed(wb_adr_i, IDX_PULLDOWN)) begin
            pulldown_reg <= wb_dat_i[7:1];
         end
         if (addressed(wb_adr_i, IDX_DIRECTION)) begin
            direction_reg <= wb_dat_i[7:1];
         end
         if (addressed(wb_adr_i, IDX_OUTPUT)) begin
            output_reg <= wb_dat_i[7:1];
         end
         if (addressed(wb_adr_i, IDX_PULLUP)) begin
            pullup_reg <= wb_dat_i[7:1];
         end
      end
   end

   // Select registers; writes are accepted at any time, but changing them
   // live glitches port power, so software loads them once.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         select_reg[0] <= power_select_t'(SELECT_RESET);
         select_reg[1] <= power_select_t'(SELECT_RESET);
      end else if (commit_write) begin
         if (addressed(wb_adr_i, IDX_SELECT1)) begin
            select_reg[0] <= power_select_t'(wb_dat_i[7:0] &
                                             SELECT_WRITE_MASK);
         end
         if (addressed(wb_adr_i, IDX_SELECT2)) begin
            select_reg[1] <= power_select_t'(wb_dat_i[7:0] &
                                             SELECT_WRITE_MASK);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pad drivers; one cycle behind the registers so outputs are flops.

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_out_o <= 7'h00;
         pad_oe_n_o <= 7'h7f;
         pad_pullup_o <= 7'h00;
         pad_pulldown_o <= 7'h00;
      end else begin
         pad_out_o <= output_reg & direction_reg;
         pad_oe_n_o <= ~direction_reg;
         pad_pullup_o <= pullup_reg;
         pad_pulldown_o <= pulldown_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-port power source selection.

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      power_source_select u_select (
         .select_i(select_reg[p]),
         .request_i({usb2_power_on_i[p], usb3_power_on_i[p],
                     gpio_sync[p]}),
         .power_on_o(power_on_next[p])
      );
   end

   // Port outputs. In shared mode the sense comes from the port's own pad,
   // pad p+1, since the power pin doubles as the over-current input.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_power_on_o <= '0;
         overcurrent_o <= '0;
         port_disabled_o <= '0;
         non_removable_attached_o <= '0;
         shared_pin_mode_o <= '0;
      end else begin
         port_power_on_o <= power_on_next;
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (select_reg[p].combined) begin
               overcurrent_o[p] <= ~pad_sync[p+1];
            end else begin
               overcurrent_o[p] <= ocs_sync[p];
            end
            port_disabled_o[p] <= select_reg[p].disabled;
            non_removable_attached_o[p] <=
               select_reg[p].non_removable_attached;
            shared_pin_mode_o[p] <= select_reg[p].combined;
         end
      end
   end

   // Status word shows the live port state to software.
   always_comb begin
      status_word = 8'h00;
      status_word[STAT_POWER_LSB +: 2] = port_power_on_o[1:0];
      status_word[STAT_OC_LSB +: 2] = overcurrent_o[1:0];
      status_word[STAT_DIS_LSB +: 2] = port_disabled_o[1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   a_pad_dir_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> pad_oe_n_o == ~$past(direction_reg))
      else $error("pad enable does not follow direction");
   a_pad_drive_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      (pad_out_o & pad_oe_n_o) == 7'h00)
      else $error("pad data driven while input");
   a_pad_out_data: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |->
      pad_out_o == ($past(output_reg) & $past(direction_reg)))
      else $error("pad data does not follow output register");
   a_pull_up_down: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> pad_pullup_o == $past(pullup_reg) &&
      pad_pulldown_o == $past(pulldown_reg))
      else $error("pull enables do not follow registers");
   a_pullup_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      commit_write && addressed(wb_adr_i, IDX_PULLUP) |=>
      ##1 pad_pullup_o == $past(wb_dat_i[7:1], 2))
      else $error("pull-up write did not reach pad");
   a_input_read: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && !wb_we_i && addressed(wb_adr_i, IDX_INPUT) |->
      wb_dat_o[7:0] == {$past(pad_sync), 1'b0})
      else $error("input register read wrong pad level");
   a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req && !wb_ack_o |-> ##1 wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_check
      a_disabled_off: assert property (@(posedge clk_i) disable iff (rst_i)
         $past(select_reg[p].disabled) |-> !port_power_on_o[p])
         else $error("disabled port has power");
      a_source_off: assert property (@(posedge clk_i) disable iff (rst_i)
         $past(select_reg[p].power_source_field) == SRC_OFF |->
         !port_power_on_o[p])
         else $error("port powered with source off");
      a_usb2_follow: assert property (@(posedge clk_i) disable iff (rst_i)
         $past(select_reg[p]) == {4'h0, SRC_USB2} |->
         port_power_on_o[p] == $past(usb2_power_on_i[p]))
         else $error("port power does not follow usb2");
      a_usb3_follow: assert property (@(posedge clk_i) disable iff (rst_i)
         $past(select_reg[p]) == {4'h0, SRC_USB3} |->
         port_power_on_o[p] == $past(usb3_power_on_i[p]))
         else $error("port power does not follow usb3");
      a_either_follow: assert property (@(posedge clk_i) disable iff (rst_i)
         $past(select_reg[p]) == {4'h0, SRC_EITHER} |->
         port_power_on_o[p] ==
         ($past(usb2_power_on_i[p]) | $past(usb3_power_on_i[p])))
         else $error("port power is not usb2 or usb3");
      a_gpio_follow: assert property (@(posedge clk_i) disable iff (rst_i)
         $past(select_reg[p]) == {4'h0, SRC_GPIO} |->
         port_power_on_o[p] == $past(gpio_sync[p]))
         else $error("port power does not follow gpio");
      a_sense_source: assert property (@(posedge clk_i) disable iff (rst_i)
         !$past(rst_i) |-> overcurrent_o[p] ==
         ($past(select_reg[p].combined) ? !$past(pad_sync[p+1]) :
          $past(ocs_sync[p])))
         else $error("over-current from wrong pin");
      a_nr_report: assert property (@(posedge clk_i) disable iff (rst_i)
         !$past(rst_i) |-> non_removable_attached_o[p] ==
         $past(select_reg[p].non_removable_attached))
         else $error("non-removable flag not reported");
   end

endmodule

// ==== port_power_switch_model.sv ====
// Model of the pads' far side: pad level resolution and an over-current sensor.
// Assumes the bench says when an outside source drives an input pad.
`timescale 1ns/1ps
module port_power_switch_model (
   input wire logic clk_i,
   input wire logic [7:1] pad_out_i,
   input wire logic [7:1] pad_oe_n_i,
   input wire logic [7:1] pad_pullup_i,
   input wire logic [7:1] pad_pulldown_i,
   input wire logic [7:1] ext_drive_i,
   input wire logic [7:1] ext_level_i,
   input wire logic [1:0] fault_i,
   output logic [7:1] pad_level_o,
   output logic [1:0] ocs_n_o
);
   logic [7:1] float_reg = 7'h55;

   // A pad nobody drives or pulls wanders, so it never holds a clean level.
   always @(posedge clk_i) begin
      float_reg <= ~float_reg;
   end

   // Pad buffer wins, then an outside driver, then the pulls.
   always_comb begin
      for (int n = 1; n <= 7; n++) begin
         if (!pad_oe_n_i[n]) begin
            pad_level_o[n] = pad_out_i[n];
         end else if (ext_drive_i[n]) begin
            pad_level_o[n] = ext_level_i[n];
         end else if (pad_pullup_i[n]) begin
            pad_level_o[n] = 1'b1;
         end else if (pad_pulldown_i[n]) begin
            pad_level_o[n] = 1'b0;
         end else begin
            pad_level_o[n] = float_reg[n];
         end
      end
   end

   // The sensor pulls its line low while it sees a fault.
   assign ocs_n_o = ~fault_i;
endmodule

// ==== port_power_ctrl_bench.sv ====
// Self-checking bench for port_power_ctrl and its pad far side model.
// Assumes a classic Wishbone slave; read results are queued and compared
// by a monitor when ack shows.
`timescale 1ns/1ps
module port_power_ctrl_bench;
   import port_power_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [15:0] wb_adr_i = 16'h0000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [7:1] pad_in_i, pad_out_o, pad_oe_n_o, pad_pullup_o, pad_pulldown_o;
   logic [7:1] ext_drive = 7'h00;
   logic [7:1] ext_level = 7'h00;
   logic [1:0] fault = 2'b00;
   logic [1:0] usb2_power_on_i = 2'b00;
   logic [1:0] usb3_power_on_i = 2'b00;
   logic [1:0] gpio_power_i = 2'b00;
   logic [1:0] ocs_n_i, port_power_on_o, overcurrent_o;
   logic [1:0] port_disabled_o, non_removable_attached_o, shared_pin_mode_o;
   logic [31:0] expect_q[$];
   int fail_count = 0;
   int num_checks = 0;

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   port_power_ctrl #(.NUM_PORTS(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in_i(pad_in_i),
      .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
      .pad_pullup_o(pad_pullup_o), .pad_pulldown_o(pad_pulldown_o),
      .usb2_power_on_i(usb2_power_on_i), .usb3_power_on_i(usb3_power_on_i),
      .gpio_power_i(gpio_power_i), .ocs_n_i(ocs_n_i),
      .port_power_on_o(port_power_on_o), .overcurrent_o(overcurrent_o),
      .port_disabled_o(port_disabled_o),
      .non_removable_attached_o(non_removable_attached_o),
      .shared_pin_mode_o(shared_pin_mode_o));

   port_power_switch_model u_far (.clk_i(clk_i), .pad_out_i(pad_out_o),
      .pad_oe_n_i(pad_oe_n_o), .pad_pullup_i(pad_pullup_o),
      .pad_pulldown_i(pad_pulldown_o), .ext_drive_i(ext_drive),
      .ext_level_i(ext_level), .fault_i(fault), .pad_level_o(pad_in_i),
      .ocs_n_o(ocs_n_i));

   ////////////////////////////////////////////////////////////////////////
   // Checking and bus tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // The request stays put until ack is sampled; the wait is bounded.
   task automatic wb_cycle(input logic we, input logic [13:0] idx,
         input logic [7:0] dat, input logic [3:0] sel);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= {24'h00_0000, dat};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         check(32'(wb_ack_o), 32'h0000_0001);
         give_verdict();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wb_write(input logic [13:0] idx, input logic [7:0] dat);
      wb_cycle(1'b1, idx, dat, 4'h1);
   endtask

   task automatic wb_read(input logic [13:0] idx, input logic [7:0] want);
      expect_q.push_back({24'h00_0000, want});
      wb_cycle(1'b0, idx, 8'h00, 4'h1);
   endtask

   // Lets synchronisers and output registers catch up, then samples.
   task automatic settle;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // Read data is taken at the edge that samples ack high.
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expect_q.size() > 0) begin
         check(wb_dat_o, expect_q.pop_front());
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [7:0] pd, pu, dir, out, sel;
      logic [7:1] drv, lvl, lev;
      logic [3:0] code;
      logic [13:0] sidx;
      logic [2:0] req;
      logic want;
      void'($urandom(92));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check(pad_oe_n_o, 7'h7f);
      check(port_power_on_o, 2'b00);
      @(negedge clk_i);
      check(overcurrent_o, 2'b00);
      wb_read(IDX_PULLDOWN, 8'h00);
      wb_read(IDX_SELECT1, 8'h00);
      wb_read(IDX_SELECT2, 8'h00);
      $display("Test reset values done");
      for (int i = 0; i < 4; i++) begin
         pd = 8'($urandom);
         pu = 8'($urandom);
         dir = 8'($urandom);
         out = 8'($urandom);
         wb_write(IDX_PULLDOWN, pd);
         wb_write(IDX_PULLUP, pu);
         wb_write(IDX_DIRECTION, dir);
         wb_write(IDX_OUTPUT, out);
         wb_read(IDX_PULLDOWN, {pd[7:1], 1'b0});
         wb_read(IDX_DIRECTION, {dir[7:1], 1'b0});
         wb_read(IDX_OUTPUT, {out[7:1], 1'b0});
         settle();
         check(pad_pulldown_o, pd[7:1]);
         check(pad_pullup_o, pu[7:1]);
         check(pad_oe_n_o, 7'(~dir[7:1]));
         check(pad_out_o, out[7:1] & dir[7:1]);
      end
      $display("Test pad control done");
      // Every input pad is pulled or driven, so its level is defined.
      drv = 7'($urandom) & ~dir[7:1];
      lvl = 7'($urandom);
      @(posedge clk_i);
      ext_drive <= drv;
      ext_level <= lvl;
      wb_write(IDX_PULLDOWN, ~pu);
      lev = (out[7:1] & dir[7:1]) |
         (~dir[7:1] & ((drv & lvl) | (~drv & pu[7:1])));
      settle();
      wb_read(IDX_INPUT, {lev, 1'b0});
      wb_write(IDX_INPUT, {~lev, 1'b1});
      wb_read(IDX_INPUT, {lev, 1'b0});
      wb_cycle(1'b1, IDX_OUTPUT, ~out, 4'h0);
      wb_read(IDX_OUTPUT, {out[7:1], 1'b0});
      wb_write(14'h0001, 8'hff);
      wb_read(14'h0001, 8'h00);
      $display("Test pad input done");
      // Selects hold only defined codes and are set before traffic.
      for (int p = 0; p < 2; p++) begin
         sidx = (p == 0) ? IDX_SELECT1 : IDX_SELECT2;
         for (int c = 0; c < 5; c++) begin
            code = 4'(c);
            sel = {8'($urandom) & 8'h90} | {4'h0, code};
            sel[5] = ($urandom % 4) == 0;
            wb_write(sidx, sel | 8'h40);
            wb_read(sidx, sel);
            for (int r = 0; r < 8; r++) begin
               req = 3'(r);
               @(posedge clk_i);
               usb2_power_on_i[p] <= req[2];
               usb3_power_on_i[p] <= req[1];
               gpio_power_i[p] <= req[0];
               settle();
               want = ((code == SRC_USB2 && req[2]) ||
                  (code == SRC_USB3 && req[1]) ||
                  (code == SRC_EITHER && req[2:1] != 2'b00) ||
                  (code == SRC_GPIO && req[0])) && !sel[5];
               check(port_power_on_o[p], want);
            end
            check(port_disabled_o[p], sel[5]);
            check(non_removable_attached_o[p], sel[4]);
            check(shared_pin_mode_o[p], sel[7]);
         end
         wb_write(sidx, 8'h00);
      end
      $display("Test power source done");
      // When a fault is set only the selected source shows it, so the mode decides the result.
      wb_write(IDX_DIRECTION, 8'h00);
      wb_write(IDX_PULLUP, 8'hfe);
      ext_drive <= 7'h7f;
      for (int p = 0; p < 2; p++) begin
         sidx = (p == 0) ? IDX_SELECT1 : IDX_SELECT2;
         for (int m = 0; m < 2; m++) begin
            wb_write(sidx, {m[0], 7'h01});
            for (int f = 0; f < 2; f++) begin
               @(posedge clk_i);
               ext_level <= ~(7'(f & m) << p);
               fault[p] <= f[0] & ~m[0];
               settle();
               check(overcurrent_o[p], f[0]);
               // Status: this port powered by usb2, its fault bit is f.
               wb_read(IDX_STATUS, 8'((1 << p) | (f << (p + 2))));
            end
         end
         wb_write(sidx, 8'h00);
         fault <= 2'b00;
      end
      $display("Test over-current done");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb_read(IDX_DIRECTION, 8'h00);
      settle();
      check(pad_oe_n_o, 7'h7f);
      check(32'(expect_q.size()), 32'h0000_0000);
      $display("Test second reset done");
      give_verdict();
   end
endmodule
